//--- rtl/pwee_regs.sv
/*
 * Password entry and single-byte EEPROM pointer/value registers.
 * Assumes the serial bus front end delivers one-cycle read and write
 * strobes on core_clk, and the EEPROM engine pulses fetch_valid when a
 * single-byte read has returned data.
 */
// Notes on behaviour
// - password word built from four bytes, lowest offset holds bits 7:0.
// - password bytes are write-only; reads always return zero.
// - pointer holds the single-byte EEPROM address, resets to C0h.
// - pointer and value always readable; their writes are password-protected.
// - value holds fetched or to-be-stored EEPROM byte, resets to 00h.
// - about 66 ms after power-up, all password bytes clear to 00h.
// - with enable code 255, protected writes are dropped without a matching password.
// - match compares all 32 bits against the stored password mirror.
`timescale 1ns/1ps
`default_nettype none
module pwee_regs #(
    parameter int FIRST_REFRESH_CYCLES = pwee_pkg::FIRST_REFRESH_CYCLES
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] password_enable_code,
    input wire logic [31:0] stored_password_mirror,
    input wire logic fetch_valid,
    input wire logic [7:0] fetch_data,
    output logic write_unlocked,
    output logic [7:0] eeprom_byte_pointer,
    output logic [7:0] eeprom_byte_value
);
    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [3:0][7:0] password_word;
        logic [7:0] pointer;
        logic [7:0] value;
        logic [7:0] rdata;
        logic [pwee_pkg::REFRESH_CNT_W-1:0] refresh_cnt;
        logic refresh_done;
    } pwee_state_t;

    localparam logic [pwee_pkg::REFRESH_CNT_W-1:0] REFRESH_LAST =
        pwee_pkg::REFRESH_CNT_W'(FIRST_REFRESH_CYCLES - 1);

    pwee_state_t state_q;
    pwee_state_t state_d;
    logic protect_on;
    logic pw_hit;
    logic refresh_clear;

    // Password bytes themselves are never protected, else no unlock path
    assign protect_on = (password_enable_code ==
                         pwee_pkg::PASSWORD_ENABLED_CODE);
    assign pw_hit = (state_q.password_word == stored_password_mirror);
    assign write_unlocked = !protect_on || pw_hit;
    assign refresh_clear = !state_q.refresh_done &&
                           (state_q.refresh_cnt == REFRESH_LAST);
    assign eeprom_byte_pointer = state_q.pointer;
    assign eeprom_byte_value = state_q.value;
    assign reg_rdata = state_q.rdata;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        state_d = state_q;
        if (!state_q.refresh_done) begin
            state_d.refresh_cnt = state_q.refresh_cnt +
                                  pwee_pkg::REFRESH_CNT_W'(1);
        end
        if (reg_wr) begin
            unique case (reg_addr)
                pwee_pkg::ADDR_PASSWORD_BYTE0: begin
                    state_d.password_word[0] = reg_wdata;
                end
                pwee_pkg::ADDR_PASSWORD_BYTE1: begin
                    state_d.password_word[1] = reg_wdata;
                end
                pwee_pkg::ADDR_PASSWORD_BYTE2: begin
                    state_d.password_word[2] = reg_wdata;
                end
                pwee_pkg::ADDR_PASSWORD_BYTE3: begin
                    state_d.password_word[3] = reg_wdata;
                end
                pwee_pkg::ADDR_EEPROM_BYTE_POINTER: begin
                    if (write_unlocked) begin
                        state_d.pointer = reg_wdata;
                    end
                end
                pwee_pkg::ADDR_EEPROM_BYTE_VALUE: begin
                    if (write_unlocked) begin
                        state_d.value = reg_wdata;
                    end
                end
                default: begin
                end
            endcase
        end
        // Fetched EEPROM data beats a host write in the same cycle
        if (fetch_valid) begin
            state_d.value = fetch_data;
        end
        // Clear after the first refresh beats a concurrent password write
        if (refresh_clear) begin
            state_d.refresh_done = 1'b1;
            state_d.password_word = {4{pwee_pkg::RST_PASSWORD_BYTE}};
        end
        if (reg_rd) begin
            unique case (reg_addr)
                pwee_pkg::ADDR_EEPROM_BYTE_POINTER: begin
                    state_d.rdata = state_q.pointer;
                end
                pwee_pkg::ADDR_EEPROM_BYTE_VALUE: begin
                    state_d.rdata = state_q.value;
                end
                default: begin
                    // Password bytes and unmapped offsets read zero
                    state_d.rdata = pwee_pkg::RDATA_WRITE_ONLY;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_q.password_word <= {4{pwee_pkg::RST_PASSWORD_BYTE}};
            state_q.pointer <= pwee_pkg::RST_EEPROM_BYTE_POINTER;
            state_q.value <= pwee_pkg::RST_EEPROM_BYTE_VALUE;
            state_q.rdata <= 8'h00;
            state_q.refresh_cnt <= '0;
            state_q.refresh_done <= 1'b0;
        end else begin
            state_q <= state_d;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_pw_low_byte: assert property (
        @(posedge core_clk) disable iff (!rstn)
        reg_wr && reg_addr == pwee_pkg::ADDR_PASSWORD_BYTE0 && !refresh_clear
        |=> state_q.password_word[0] == $past(reg_wdata))
        else $error("password byte 0 not stored in bits 7:0");
    a_pw_high_byte: assert property (
        @(posedge core_clk) disable iff (!rstn)
        reg_wr && reg_addr == pwee_pkg::ADDR_PASSWORD_BYTE3 && !refresh_clear
        |=> state_q.password_word[3] == $past(reg_wdata))
        else $error("password byte 3 not stored in bits 31:24");
    a_pw_read_zero: assert property (
        @(posedge core_clk) disable iff (!rstn)
        reg_rd && reg_addr >= pwee_pkg::ADDR_PASSWORD_BYTE0 &&
        reg_addr <= pwee_pkg::ADDR_PASSWORD_BYTE3 |=> reg_rdata == 8'h00)
        else $error("password byte read returned nonzero");
    a_ptr_hold: assert property (
        @(posedge core_clk) disable iff (!rstn)
        !(reg_wr && reg_addr == pwee_pkg::ADDR_EEPROM_BYTE_POINTER)
        |=> $stable(eeprom_byte_pointer))
        else $error("pointer changed without a write");
    a_ptr_readback: assert property (
        @(posedge core_clk) disable iff (!rstn)
        reg_rd && reg_addr == pwee_pkg::ADDR_EEPROM_BYTE_POINTER
        |=> reg_rdata == $past(eeprom_byte_pointer))
        else $error("pointer read mismatch");
    a_fetch_load: assert property (
        @(posedge core_clk) disable iff (!rstn)
        fetch_valid |=> eeprom_byte_value == $past(fetch_data))
        else $error("fetched byte not loaded");
    a_refresh_clear: assert property (
        @(posedge core_clk) disable iff (!rstn)
        $rose(state_q.refresh_done) |-> state_q.password_word == 32'h0 ##1
        state_q.refresh_done [*3])
        else $error("password not cleared after first refresh");
    a_lock_match: assert property (
        @(posedge core_clk) disable iff (!rstn)
        password_enable_code == 8'hFF &&
        state_q.password_word != stored_password_mirror |-> !write_unlocked)
        else $error("unlocked without matching password");
    a_locked_drop: assert property (
        @(posedge core_clk) disable iff (!rstn)
        reg_wr && reg_addr == pwee_pkg::ADDR_EEPROM_BYTE_VALUE &&
        !write_unlocked && !fetch_valid |=> $stable(eeprom_byte_value))
        else $error("locked write changed value register");
    a_pw_byte_one: assert property (
        @(posedge core_clk) disable iff (!rstn)
        reg_wr && reg_addr == pwee_pkg::ADDR_PASSWORD_BYTE1 && !refresh_clear
        |=> state_q.password_word[1] == $past(reg_wdata))
        else $error("password byte 1 not stored in bits 15:8");
    a_pw_byte_two: assert property (
        @(posedge core_clk) disable iff (!rstn)
        reg_wr && reg_addr == pwee_pkg::ADDR_PASSWORD_BYTE2 && !refresh_clear
        |=> state_q.password_word[2] == $past(reg_wdata))
        else $error("password byte 2 not stored in bits 23:16");
    a_ptr_write: assert property (
        @(posedge core_clk) disable iff (!rstn)
        reg_wr && reg_addr == pwee_pkg::ADDR_EEPROM_BYTE_POINTER &&
        write_unlocked |=> eeprom_byte_pointer == $past(reg_wdata))
        else $error("unlocked pointer write not stored");
    a_ptr_locked: assert property (
        @(posedge core_clk) disable iff (!rstn)
        reg_wr && reg_addr == pwee_pkg::ADDR_EEPROM_BYTE_POINTER &&
        !write_unlocked |=> $stable(eeprom_byte_pointer))
        else $error("locked write changed pointer register");
    a_val_write: assert property (
        @(posedge core_clk) disable iff (!rstn)
        reg_wr && reg_addr == pwee_pkg::ADDR_EEPROM_BYTE_VALUE &&
        write_unlocked && !fetch_valid
        |=> eeprom_byte_value == $past(reg_wdata))
        else $error("unlocked value write not stored");
    a_val_readback: assert property (
        @(posedge core_clk) disable iff (!rstn)
        reg_rd && reg_addr == pwee_pkg::ADDR_EEPROM_BYTE_VALUE
        |=> reg_rdata == $past(eeprom_byte_value))
        else $error("value read mismatch");
    a_rdata_hold: assert property (
        @(posedge core_clk) disable iff (!rstn)
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");
    a_clear_wins: assert property (
        @(posedge core_clk) disable iff (!rstn)
        refresh_clear
        |=> state_q.password_word == 32'h0 && state_q.refresh_done)
        else $error("password survived the first refresh clear");
    a_refresh_once: assert property (
        @(posedge core_clk) disable iff (!rstn)
        state_q.refresh_done |=> state_q.refresh_done)
        else $error("refresh done flag fell again");
    a_unlock_open: assert property (
        @(posedge core_clk) disable iff (!rstn)
        password_enable_code != pwee_pkg::PASSWORD_ENABLED_CODE
        |-> write_unlocked)
        else $error("locked although protection is off");
    a_unlock_match: assert property (
        @(posedge core_clk) disable iff (!rstn)
        state_q.password_word == stored_password_mirror |-> write_unlocked)
        else $error("locked although password matches");
endmodule
`default_nettype wire

//--- rtl/pwee_pkg.sv
/*
 * Constants for the password and EEPROM byte access register slice.
 * Assumes an 8-bit register address space on a single core clock.
 */
package pwee_pkg;
    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0] ADDR_PASSWORD_BYTE0 = 8'h39;
    localparam logic [7:0] ADDR_PASSWORD_BYTE1 = 8'h3A;
    localparam logic [7:0] ADDR_PASSWORD_BYTE2 = 8'h3B;
    localparam logic [7:0] ADDR_PASSWORD_BYTE3 = 8'h3C;
    localparam logic [7:0] ADDR_EEPROM_BYTE_POINTER = 8'h3D;
    localparam logic [7:0] ADDR_EEPROM_BYTE_VALUE = 8'h3E;

    // ****************************************************************
    // Reset values and codes
    // ****************************************************************
    localparam logic [7:0] RST_PASSWORD_BYTE = 8'h00;
    localparam logic [7:0] RST_EEPROM_BYTE_POINTER = 8'hC0;
    localparam logic [7:0] RST_EEPROM_BYTE_VALUE = 8'h00;
    localparam logic [7:0] RDATA_WRITE_ONLY = 8'h00;
    localparam logic [7:0] PASSWORD_ENABLED_CODE = 8'hFF;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CORE_CLK_HZ = 200_000_000;
    localparam int FIRST_REFRESH_MS = 66;
    localparam int FIRST_REFRESH_CYCLES = FIRST_REFRESH_MS * (CORE_CLK_HZ / 1000);
    localparam int REFRESH_CNT_W = 24;
endpackage

//--- bench/pwee_fetch_model.sv
/* EEPROM engine model that answers a single-byte fetch.
   Assumes the bench pulses req by non-blocking assignment and holds
   rstn low over at least one falling clock edge. */
`timescale 1ns/1ps
`default_nettype none
module pwee_fetch_model (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic req,
    input wire logic [3:0] delay,
    input wire logic [7:0] value,
    output logic fetch_valid,
    output logic [7:0] fetch_data
);
    logic busy_q;
    logic [3:0] cnt_q;
    // Data toggles outside the valid cycle so a stale byte never passes
    always @(negedge core_clk) begin
        if (!rstn) begin
            busy_q <= 1'h0;
            cnt_q <= 4'h0;
            fetch_valid <= 1'h0;
            fetch_data <= 8'h00;
        end else begin
            fetch_valid <= 1'h0;
            fetch_data <= ~fetch_data;
            if (req && !busy_q) begin
                busy_q <= 1'h1;
                cnt_q <= delay;
            end else if (busy_q && cnt_q == 4'h0) begin
                busy_q <= 1'h0;
                fetch_valid <= 1'h1;
                fetch_data <= value;
            end else if (busy_q) begin
                cnt_q <= cnt_q - 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

//--- bench/pwee_regs_bench.sv
/* Self-checking bench for the password and EEPROM byte registers.
   Assumes a 200 MHz core clock and a shortened refresh count. */
`timescale 1ns/1ps
`default_nettype none
module pwee_regs_bench;
    logic core_clk = 1'h0;
    logic rstn = 1'h0;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic fetch_req = 1'h0;
    logic rd_p = 1'h0;
    logic fetch_valid, unl;
    logic [3:0] dly = 4'h0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, code = 8'h00;
    logic [7:0] fd = 8'h00, r, reg_rdata, fetch_data, ptr, val;
    logic [31:0] mirror = 32'h0, m;
    logic [7:0] expq[$];
    int err_count = 0, num_checks = 0, cyc = 0;
    always #2.5 core_clk = ~core_clk;
    pwee_regs #(.FIRST_REFRESH_CYCLES(400)) uut (.core_clk(core_clk),
        .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .password_enable_code(code), .stored_password_mirror(mirror),
        .fetch_valid(fetch_valid), .fetch_data(fetch_data),
        .write_unlocked(unl), .eeprom_byte_pointer(ptr),
        .eeprom_byte_value(val));
    pwee_fetch_model fm (.core_clk(core_clk), .rstn(rstn),
        .req(fetch_req), .delay(dly),
        .value(fd), .fetch_valid(fetch_valid), .fetch_data(fetch_data));
    task chk(string n, logic [31:0] e, logic [31:0] s);
        num_checks++;
        if (s !== e) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask
    task wr(logic [7:0] a, logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'h1;
        @(negedge core_clk);
        reg_wr = 1'h0;
    endtask
    task rd(logic [7:0] a, logic [7:0] e);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'h1;
        expq.push_back(e);
        @(negedge core_clk);
        reg_rd = 1'h0;
    endtask
    task conclude();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Read data lands on the strobe's edge, so compare one edge later
    always @(posedge core_clk) begin
        rd_p <= reg_rd;
        cyc++;
        if (rd_p) chk("reg_rdata", expq.pop_front(), reg_rdata);
        if (cyc == 2000) begin
            err_count++;
            conclude();
        end
    end
    initial begin
        r = 8'($urandom(10161));
        repeat (2) @(negedge core_clk);
        rstn = 1'h1;
        rd(8'h3D, 8'hC0);
        rd(8'h3E, 8'h00);
        rd(8'h39, 8'h00);
        rd(8'h40, 8'h00);
        chk("pointer", 8'hC0, ptr);
        chk("value", 8'h00, val);
        $display("test reset done");
        r = 8'($urandom);
        wr(8'h3D, r);
        chk("pointer", r, ptr);
        rd(8'h3D, r);
        wr(8'h3E, ~r);
        rd(8'h3E, ~r);
        wr(8'h3B, r);
        rd(8'h3B, 8'h00);
        $display("test open access done");
        m = $urandom;
        code = 8'hFF;
        mirror = m;
        for (int i = 0; i < 4; i++) wr(8'h39 + 8'(i), ~m[8*i+:8]);
        chk("unlocked", 0, unl);
        wr(8'h3D, ~r);
        chk("pointer", r, ptr);
        rd(8'h3D, r);
        for (int i = 0; i < 4; i++) begin
            wr(8'h39 + 8'(i), m[8*i+:8]);
            chk("unlocked", i == 3, unl);
        end
        wr(8'h3D, ~r);
        rd(8'h3D, ~r);
        code = 8'hFE;
        mirror = ~m;
        #1 chk("unlocked", 1, unl);
        code = 8'hFF;
        $display("test protection done");
        for (int k = 0; k < 2; k++) begin
            fd = 8'($urandom);
            dly = k ? 4'h9 : 4'h0;
            // Engine is asked only while idle, one single-byte read a time
            fetch_req <= 1'h1;
            @(negedge core_clk);
            fetch_req <= 1'h0;
            for (int t = 0; t < 20 && fetch_valid !== 1'h1; t++)
                @(posedge core_clk);
            rd(8'h3E, fd);
            chk("value", fd, val);
        end
        wr(8'h3E, ~fd);
        chk("value", fd, val);
        rd(8'h3E, fd);
        // Open writes, then a fetch that lands with a host write to value
        code = 8'hFE;
        wr(8'h3E, ~fd);
        chk("value", 8'(~fd), val);
        fd = 8'($urandom);
        dly = 4'h0;
        fetch_req <= 1'h1;
        @(negedge core_clk);
        fetch_req <= 1'h0;
        wr(8'h3E, ~fd);
        chk("value", fd, val);
        code = 8'hFF;
        mirror = 32'h0;
        #1 chk("unlocked", 0, unl);
        while (cyc < 420) @(negedge core_clk);
        chk("unlocked", 1, unl);
        $display("test refresh clear done");
        repeat (3) @(negedge core_clk);
        conclude();
    end
endmodule
`default_nettype wire
